// file: hdl/spg_sector_guard.sv
// Purpose: Sector protection control with guard map and command decode.
// Assumes: Host bus pins are sampled; each strobe high/low lasts >= 3 clocks.
// Notes: Map program ANDs staged bytes into the map, as flash would.
// Contract
// (R1) Write-protect low refuses ops on marked sectors
// (R2) Pin assertion turns guard on within latency
// (R3) Pin release drops guard unless enable seen
// (R4) Enable command keeps guard on after release
// (R5) Disable command ignored while pin asserted
// (R6) Filter short pin glitches
// (R7) Map holds 32 bytes, byte n sector n
// (R8) FFH protected, 00H unprotected; host writes those
// (R9) Sector 0: bits 7:6 pages 0-7, 5:4 rest
// (R10) Host erases map before programming it
// (R11) Erase frame 3D 2A 7F CF, busy timed
// (R12) Erase sets every map byte to FFH
// (R13) Erase accepted with guard on or off
// (R14) Program frame 3D 2A 7F FC, 32 bytes
// (R15) Frame end starts timed program, busy shown
// (R16) Byte pointer wraps after 32 bytes
// (R17) Host sends all 32 bytes per program
// (R18) Program accepted with guard on or off
// (R19) Program stages bytes in data buffer
// (R20) Erased map with guard on refuses all
// (R21) Map starts at 00H everywhere
// (R22) Enable frame 3D 2A 7F A9 sets guard
// (R23) Disable frame 3D 2A 7F 9A clears guard
// (R24) Power-up leaves command guard off
// (R25) Write-protect pin is active low
// (R26) No new erase or program while busy
`timescale 1ns/1ps
`include "spg_cfg.svh"
module spg_sector_guard #(
  parameter int FILT_CYC = `SPG_CYC_MIN(`SPG_WP_FILTER_NS),
  parameter int ERASE_CYC = `SPG_CYC_MAX(`SPG_ERASE_NS),
  parameter int PROG_CYC = `SPG_CYC_MAX(`SPG_PROG_NS)
) (
  input wire logic i_sys_clk, // System clock, 50 MHz
  input wire logic i_reset_n, // Async reset, active low
  input wire logic i_cs_n, // Chip select pin, active low
  input wire logic i_bus_clk, // Host byte strobe pin, rising edge
  input wire logic [7:0] i_parallel_bus, // Host command/data byte
  input wire logic i_wp_n, // Write-protect pin, active low
  input wire logic i_op_req, // Main array op request pulse
  input wire logic [4:0] i_op_sector, // Sector of the op
  input wire logic [7:0] i_op_page, // Page within sector
  output logic o_op_grant, // Op allowed, pulse
  output logic o_op_deny, // Op refused, pulse
  output logic o_busy, // Map cycle running
  output logic o_guard_on, // Sector protection active
  output logic o_wp_active, // Filtered pin asserted
  output logic [255:0] o_guard_map // Sector guard map
);
  localparam int TW = $clog2(ERASE_CYC + PROG_CYC) + 1;
  localparam int GON = `SPG_CYC_MAX(`SPG_GUARD_ON_NS);
  localparam int GOFF = `SPG_CYC_MAX(`SPG_GUARD_OFF_NS);

  typedef struct packed {
    logic [`SPG_SECTORS-1:0][7:0] map;
    logic [`SPG_SECTORS-1:0][7:0] scratch;
    logic sw_en;
    logic clk_d;
    logic cs_d;
    logic [2:0] nbytes;
    spg_pkg::spg_cmd_type cmd;
    logic [4:0] ptr;
    spg_pkg::spg_cycle_type cyc;
    logic [TW-1:0] timer;
    logic grant;
    logic deny;
  } spg_core_state_type;

  spg_core_state_type q;
  spg_core_state_type n;
  logic rst_n;
  logic [10:0] pins_s;
  logic [7:0] bus_s;
  logic bus_clk_s;
  logic cs_n_s;
  logic wp_n_s;
  logic wp_on;
  logic byte_stb;
  logic cs_rise;
  logic frame_ok;
  logic busy;
  logic guard_on;
  logic [`SPG_SECTORS-1:0] mark_s;

  // Fourth opcode byte to command
  function automatic spg_pkg::spg_cmd_type spg_decode(input logic [7:0] b);
    spg_pkg::spg_cmd_type c;
    c = spg_pkg::SPG_CMD_BAD;
    if (b == `SPG_OP_ERASE)
      c = spg_pkg::SPG_CMD_ERASE; // [R11]
    else if (b == `SPG_OP_PROG)
      c = spg_pkg::SPG_CMD_PROG; // [R14]
    else if (b == `SPG_OP_ENA)
      c = spg_pkg::SPG_CMD_ENA; // [R22]
    else if (b == `SPG_OP_DIS)
      c = spg_pkg::SPG_CMD_DIS; // [R23]
    return c;
  endfunction : spg_decode

  // Expected prefix byte at position i
  function automatic logic [7:0] spg_prefix(input logic [2:0] i);
    return (i == 3'h0) ? `SPG_PFX0 : (i == 3'h1) ? `SPG_PFX1 : `SPG_PFX2;
  endfunction : spg_prefix

  // Reset release through two flops
  spg_pin_sync #(.W(1), .RST(1'h0)) u_rst_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_reset_n),
    .i_async(1'h1),
    .o_sync(rst_n)
  );

  // Host pins into the clock domain
  spg_pin_sync #(.W(11), .RST(11'h600)) u_pin_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(rst_n),
    .i_async({i_wp_n, i_cs_n, i_bus_clk, i_parallel_bus}),
    .o_sync(pins_s)
  );

  // Write-protect glitch filter
  spg_wp_filter #(.FILT(FILT_CYC)) u_wp_filter (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(rst_n),
    .i_wp_n_sync(wp_n_s),
    .o_wp_on(wp_on)
  );

  // Pin fields, strobes and frame status
  assign bus_s = pins_s[7:0];
  assign bus_clk_s = pins_s[8];
  assign cs_n_s = pins_s[9];
  assign wp_n_s = pins_s[10];
  assign byte_stb = bus_clk_s && !q.clk_d && !cs_n_s;
  assign cs_rise = cs_n_s && !q.cs_d;
  assign frame_ok = cs_rise && (q.nbytes == `SPG_OP_BYTES);
  assign busy = (q.cyc != spg_pkg::SPG_IDLE);
  assign guard_on = q.sw_en || wp_on; // [R2] [R3]

  // Per-sector mark: sector 0 split by page, others by whole byte
  for (genvar g = 0; g < `SPG_SECTORS; g++)
  begin : g_mark
    if (g == 0)
    begin : g_s0
      assign mark_s[g] = (i_op_page <= `SPG_S0A_LAST_PAGE) ?
        (&q.map[0][7:6]) : (&q.map[0][5:4]); // [R9]
    end
    else
    begin : g_sn
      assign mark_s[g] = (q.map[g] != `SPG_MARK_OFF); // [R8] [R7]
    end
  end

  // Next state: byte decode, frame end, map cycle, op check
  always_comb
  begin
    n = q;
    n.grant = 1'h0;
    n.deny = 1'h0;
    n.clk_d = bus_clk_s;
    n.cs_d = cs_n_s;
    if (byte_stb && q.nbytes != `SPG_OP_BYTES)
    begin
      n.nbytes = q.nbytes + 3'h1;
      if (q.nbytes == 3'h3)
      begin
        if (q.cmd != spg_pkg::SPG_CMD_BAD)
          n.cmd = spg_decode(bus_s);
      end
      else if (bus_s != spg_prefix(q.nbytes))
        n.cmd = spg_pkg::SPG_CMD_BAD;
    end
    else if (byte_stb && q.cmd == spg_pkg::SPG_CMD_PROG && !busy)
    begin
      n.scratch[q.ptr] = bus_s; // [R14] [R19]
      n.ptr = q.ptr + 5'h1; // [R16]
    end
    if (cs_rise)
    begin
      n.nbytes = '0;
      n.cmd = spg_pkg::SPG_CMD_NONE;
      n.ptr = '0;
    end
    if (frame_ok && q.cmd == spg_pkg::SPG_CMD_ENA)
      n.sw_en = 1'h1; // [R22] [R4]
    if (frame_ok && q.cmd == spg_pkg::SPG_CMD_DIS && !wp_on)
      n.sw_en = 1'h0; // [R23] [R5]
    case (q.cyc)
      spg_pkg::SPG_IDLE:
      begin
        if (frame_ok && q.cmd == spg_pkg::SPG_CMD_ERASE)
        begin
          n.cyc = spg_pkg::SPG_ERASING; // [R11] [R13]
          n.timer = TW'(ERASE_CYC - 1);
        end
        else if (frame_ok && q.cmd == spg_pkg::SPG_CMD_PROG)
        begin
          n.cyc = spg_pkg::SPG_PROGRAMMING; // [R15] [R18]
          n.timer = TW'(PROG_CYC - 1);
        end
      end
      spg_pkg::SPG_ERASING:
      begin
        if (q.timer == '0)
        begin
          n.map = {`SPG_SECTORS{`SPG_MARK_ON}}; // [R12]
          n.cyc = spg_pkg::SPG_IDLE;
        end
        else
          n.timer = q.timer - TW'(1); // [R26]
      end
      spg_pkg::SPG_PROGRAMMING:
      begin
        if (q.timer == '0)
        begin
          n.map = q.map & q.scratch;
          n.cyc = spg_pkg::SPG_IDLE;
        end
        else
          n.timer = q.timer - TW'(1); // [R26]
      end
      default:
        n.cyc = spg_pkg::SPG_IDLE;
    endcase
    if (i_op_req)
    begin
      if (busy || (guard_on && mark_s[i_op_sector]))
        n.deny = 1'h1; // [R1] [R20] [R26]
      else
        n.grant = 1'h1;
    end
  end

  // State register; map clear and command guard off at reset
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0; // [R21] [R24]
      q.cs_d <= 1'h1;
    end
    else
      q <= n;
  end

  // Outputs
  assign o_op_grant = q.grant;
  assign o_op_deny = q.deny;
  assign o_busy = busy;
  assign o_guard_on = guard_on;
  assign o_wp_active = wp_on;
  assign o_guard_map = q.map;

  // Checks
  sequence s_glitch;
    (wp_n_s && !wp_on) ##1 !wp_n_s ##1 wp_n_s;
  endsequence

  sequence s_erase_start;
    frame_ok && q.cmd == spg_pkg::SPG_CMD_ERASE && !busy;
  endsequence

  property p_deny_marked;
    @(posedge i_sys_clk) disable iff (!rst_n)
    (i_op_req && wp_on && mark_s[i_op_sector]) |=> o_op_deny && !o_op_grant;
  endproperty
  a_deny_marked: assert property (p_deny_marked) // [R1]
    else $error("op on marked sector not refused");

  property p_guard_on;
    @(posedge i_sys_clk) disable iff (!rst_n)
    $fell(wp_n_s) |-> ##[1:GON] (o_guard_on || wp_n_s);
  endproperty
  a_guard_on: assert property (p_guard_on) // [R2]
    else $error("guard not on after pin assertion");

  property p_guard_off;
    @(posedge i_sys_clk) disable iff (!rst_n)
    ($rose(wp_n_s) && !q.sw_en) |->
      ##[1:GOFF] (!o_guard_on || !wp_n_s || q.sw_en);
  endproperty
  a_guard_off: assert property (p_guard_off) // [R3]
    else $error("guard not off after pin release");

  property p_glitch;
    @(posedge i_sys_clk) disable iff (!rst_n)
    s_glitch |-> !wp_on ##1 !wp_on;
  endproperty
  a_glitch: assert property (p_glitch) // [R6]
    else $error("pin glitch changed filtered level");

  property p_dis_ignored;
    @(posedge i_sys_clk) disable iff (!rst_n)
    (frame_ok && q.cmd == spg_pkg::SPG_CMD_DIS && wp_on && q.sw_en)
      |=> q.sw_en;
  endproperty
  a_dis_ignored: assert property (p_dis_ignored) // [R5]
    else $error("disable taken while pin asserted");

  property p_sw_hold;
    @(posedge i_sys_clk) disable iff (!rst_n)
    (q.sw_en && !(frame_ok && q.cmd == spg_pkg::SPG_CMD_DIS)) |=> q.sw_en;
  endproperty
  a_sw_hold: assert property (p_sw_hold) // [R4]
    else $error("command guard dropped without disable");

  property p_erase;
    @(posedge i_sys_clk) disable iff (!rst_n)
    s_erase_start |=> o_busy && q.cyc == spg_pkg::SPG_ERASING &&
      q.timer == TW'(ERASE_CYC - 1);
  endproperty
  a_erase: assert property (p_erase) // [R13]
    else $error("erase frame did not start busy cycle");

  property p_erase_done;
    @(posedge i_sys_clk) disable iff (!rst_n)
    (q.cyc == spg_pkg::SPG_ERASING && q.timer == '0)
      |=> (o_guard_map == {`SPG_SECTORS{`SPG_MARK_ON}}) && !o_busy;
  endproperty
  a_erase_done: assert property (p_erase_done) // [R12]
    else $error("erase did not set map to all ones");

  property p_no_restart;
    @(posedge i_sys_clk) disable iff (!rst_n)
    (busy && q.timer != '0) |=> q.cyc == $past(q.cyc) &&
      q.timer == $past(q.timer) - TW'(1);
  endproperty
  a_no_restart: assert property (p_no_restart) // [R26]
    else $error("map cycle restarted while busy");

  property p_wrap;
    @(posedge i_sys_clk) disable iff (!rst_n)
    (byte_stb && q.cmd == spg_pkg::SPG_CMD_PROG && !busy &&
      q.nbytes == `SPG_OP_BYTES && q.ptr == 5'h1F && !cs_rise)
      |=> q.ptr == 5'h00;
  endproperty
  a_wrap: assert property (p_wrap) // [R16]
    else $error("data pointer did not wrap");
endmodule : spg_sector_guard

// file: common/spg_cfg.svh
// Purpose: Constants of the sector guard block: opcodes, marks, timing.
// Assumes: 50 MHz system clock.
// Notes: Latency and cycle times are in ns; cycle counts derive from them.
`ifndef SPG_CFG_SVH
`define SPG_CFG_SVH

// Command prefix and final opcode bytes
`define SPG_PFX0 8'h3D
`define SPG_PFX1 8'h2A
`define SPG_PFX2 8'h7F
`define SPG_OP_ERASE 8'hCF
`define SPG_OP_PROG 8'hFC
`define SPG_OP_ENA 8'hA9
`define SPG_OP_DIS 8'h9A
`define SPG_OP_BYTES 3'h4

// Guard map layout and marks
`define SPG_SECTORS 32
`define SPG_MARK_ON 8'hFF
`define SPG_MARK_OFF 8'h00
`define SPG_S0A_LAST_PAGE 8'h07

// Timing in ns and cycle conversion
`define SPG_CLK_NS 20
`define SPG_WP_FILTER_NS 100
`define SPG_GUARD_ON_NS 1000
`define SPG_GUARD_OFF_NS 1000
`define SPG_ERASE_NS 40000
`define SPG_PROG_NS 40000
`define SPG_CYC_MIN(ns) (((ns) + `SPG_CLK_NS - 1) / `SPG_CLK_NS)
`define SPG_CYC_MAX(ns) ((ns) / `SPG_CLK_NS)

`endif

// file: common/spg_pkg.sv
// Purpose: Types shared by the sector guard block.
// Assumes: Nothing.
// Notes: Enumerations carry no explicit codes.
package spg_pkg;

  // Self-timed map cycle
  typedef enum logic [1:0] {
    SPG_IDLE,
    SPG_ERASING,
    SPG_PROGRAMMING
  } spg_cycle_type;

  // Command decoded from the current frame
  typedef enum logic [2:0] {
    SPG_CMD_NONE,
    SPG_CMD_ERASE,
    SPG_CMD_PROG,
    SPG_CMD_ENA,
    SPG_CMD_DIS,
    SPG_CMD_BAD
  } spg_cmd_type;

endpackage : spg_pkg

// file: hdl/spg_pin_sync.sv
// Purpose: Two-stage synchroniser for pins and reset release.
// Assumes: Inputs are asynchronous to i_sys_clk.
// Notes: Only the second stage is visible outside.
`timescale 1ns/1ps
module spg_pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic i_sys_clk, // System clock
  input wire logic i_rst_n, // Async reset, active low
  input wire logic [W-1:0] i_async, // Raw inputs
  output logic [W-1:0] o_sync // Synchronised copy
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } spg_sync_state_type;

  spg_sync_state_type s_q;
  spg_sync_state_type s_d;

  // Shift the pins through two stages
  always_comb
  begin
    s_d.meta = i_async;
    s_d.sync = s_q.meta;
  end

  // State register
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      s_q <= {RST, RST};
    else
      s_q <= s_d;
  end

  assign o_sync = s_q.sync;
endmodule : spg_pin_sync

// file: hdl/spg_wp_filter.sv
// Purpose: Noise filter on the synchronised write-protect pin.
// Assumes: Input already synchronised; pin is active low.
// Notes: A new level is taken only after FILT equal samples in a row.
`timescale 1ns/1ps
module spg_wp_filter #(
  parameter int FILT = 5
) (
  input wire logic i_sys_clk, // System clock
  input wire logic i_rst_n, // Reset, active low
  input wire logic i_wp_n_sync, // Synchronised pin level
  output logic o_wp_on // Filtered: pin asserted
);
  localparam int FW = $clog2(FILT) + 1;

  typedef struct packed {
    logic level_n;
    logic [FW-1:0] cnt;
  } spg_filt_state_type;

  spg_filt_state_type f_q;
  spg_filt_state_type f_d;

  // Count differing samples; a glitch shorter than FILT restarts it
  always_comb
  begin
    f_d = f_q;
    if (i_wp_n_sync == f_q.level_n)
      f_d.cnt = '0; // [R6]
    else if (f_q.cnt == FW'(FILT - 1))
    begin
      f_d.level_n = i_wp_n_sync;
      f_d.cnt = '0;
    end
    else
      f_d.cnt = f_q.cnt + FW'(1);
  end

  // State register, pin taken as released at reset
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      f_q.level_n <= 1'h1;
      f_q.cnt <= '0;
    end
    else
      f_q <= f_d;
  end

  assign o_wp_on = !f_q.level_n; // [R25]
endmodule : spg_wp_filter

// file: sim/spg_host_model.sv
// Purpose: Host side of the byte link: frames of prefix, opcode, data.
// Assumes: Strobe and data timing as the guard block expects.
// Notes: The bus shows the inverse of the last byte between frames.
`timescale 1ns/1ps
module spg_host_model (
  input wire logic i_sys_clk, // System clock
  output logic o_cs_n, // Chip select, active low
  output logic o_bus_clk, // Byte strobe
  output logic [7:0] o_parallel_bus // Command or data byte
);
  logic [7:0] payload [33];
  // Idle pins from time zero
  initial
  begin
    o_cs_n = 1'b1;
    o_bus_clk = 1'b0;
    o_parallel_bus = 8'h00;
  end
  // Wait n edges, then step just off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask : tick
  // Set up 3 clocks before the rise, hold through the high phase
  task automatic put_byte(input logic [7:0] v);
    o_parallel_bus = v;
    tick(3);
    o_bus_clk = 1'b1;
    tick(3);
    o_bus_clk = 1'b0;
    tick(1);
    o_parallel_bus = ~v; // No stale copy left on the bus
  endtask : put_byte
  // Whole frame; caller erases the map before programming it
  task automatic frame(input logic [7:0] op, input int n);
    tick(4);
    o_cs_n = 1'b0;
    tick(3);
    put_byte(8'h3D);
    put_byte(8'h2A);
    put_byte(8'h7F);
    put_byte(op);
    for (int i = 0; i < n; i++)
      put_byte(payload[i]); // Slots 0 to n-1 sent, only 00H/FFH/C0H
    tick(3);
    o_cs_n = 1'b1;
  endtask : frame
endmodule : spg_host_model

// file: sim/sector_protection_control_test.sv
// Purpose: Self-checking bench of the sector guard block.
// Assumes: Map cycles shortened to 4 clocks.
// Notes: Each test is one task that judges its own outcome.
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    total_checks++; \
    if ((a) !== (b)) \
    begin \
      num_errors++; \
      $display("[ERR] %0t got %0h exp %0h", $time, a, b); \
    end \
  end
module sector_protection_control_test;
  logic clk;
  logic rst_n;
  logic wp_n;
  logic req;
  logic [4:0] sec;
  logic [7:0] pg;
  logic cs_n;
  logic bclk;
  logic [7:0] pbus;
  logic grant;
  logic deny;
  logic busy;
  logic guard;
  logic wpa;
  logic [255:0] map;
  logic [7:0] exp_b;
  int num_errors = 0;
  int total_checks = 0;
  spg_host_model host (
    .i_sys_clk(clk),
    .o_cs_n(cs_n),
    .o_bus_clk(bclk),
    .o_parallel_bus(pbus)
  );
  spg_sector_guard #(.ERASE_CYC(4), .PROG_CYC(4)) dut (
    .i_sys_clk(clk),
    .i_reset_n(rst_n),
    .i_cs_n(cs_n),
    .i_bus_clk(bclk),
    .i_parallel_bus(pbus),
    .i_wp_n(wp_n),
    .i_op_req(req),
    .i_op_sector(sec),
    .i_op_page(pg),
    .o_op_grant(grant),
    .o_op_deny(deny),
    .o_busy(busy),
    .o_guard_on(guard),
    .o_wp_active(wpa),
    .o_guard_map(map)
  );
  // Free-running 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  // Wait a bounded time for busy (g low) or guard (g high) to reach v
  task automatic wait_lvl(input bit g, input logic v);
    for (int n = 0; n < 50 && (g ? guard : busy) !== v; n++)
      step(1);
  endtask : wait_lvl
  // One op request; verdict is checked one cycle later
  task automatic ask(input logic [4:0] s, input logic [7:0] p,
    input logic ok);
    sec = s;
    pg = p;
    req = 1'b1;
    step(1);
    req = 1'b0;
    `CHK({grant, deny}, {ok, ~ok})
    step(1);
  endtask : ask
  // Map cycle: busy shows, ops are refused, then busy drops
  task automatic map_cycle();
    wait_lvl(1'b0, 1'b1);
    `CHK(busy, 1'b1)
    ask(5'h02, 8'h00, 1'b0);
    wait_lvl(1'b0, 1'b0);
    `CHK(busy, 1'b0)
  endtask : map_cycle
  task automatic t_reset();
    `CHK(map, {256{1'b0}})
    `CHK(guard, 1'b0)
    ask(5'h05, 8'h00, 1'b1);
    $display("reset test done");
  endtask : t_reset
  task automatic t_pin();
    wp_n = 1'b0;
    step(1);
    wp_n = 1'b1;
    step(12);
    `CHK(wpa, 1'b0)
    wp_n = 1'b0;
    wait_lvl(1'b1, 1'b1);
    `CHK(guard, 1'b1)
    ask(5'h03, 8'h00, 1'b1);
    wp_n = 1'b1;
    wait_lvl(1'b1, 1'b0);
    `CHK(guard, 1'b0)
    $display("pin test done");
  endtask : t_pin
  task automatic t_erase();
    host.frame(8'hCF, 0);
    map_cycle();
    `CHK(map, {256{1'b1}})
    ask(5'h07, 8'h00, 1'b1);
    host.frame(8'hA9, 0);
    step(6);
    `CHK(guard, 1'b1)
    ask(5'h09, 8'h00, 1'b0);
    $display("erase test done");
  endtask : t_erase
  task automatic t_prog();
    for (int i = 0; i < 32; i++)
      host.payload[i] = i[0] ? 8'h00 : 8'hFF;
    host.payload[32] = 8'hC0;
    host.frame(8'hFC, 33);
    map_cycle();
    for (int i = 0; i < 32; i++)
    begin
      exp_b = (i == 0) ? 8'hC0 : host.payload[i];
      `CHK(map[8*i+:8], exp_b)
    end
    ask(5'h00, 8'h07, 1'b0);
    ask(5'h00, 8'h08, 1'b1);
    ask(5'h01, 8'h00, 1'b1);
    $display("program test done");
  endtask : t_prog
  task automatic t_cmd();
    wp_n = 1'b0;
    step(10);
    host.frame(8'h9A, 0);
    step(6);
    `CHK(wpa, 1'b1)
    wp_n = 1'b1;
    step(60);
    `CHK(guard, 1'b1)
    host.frame(8'h9A, 0);
    step(6);
    `CHK(guard, 1'b0)
    wp_n = 1'b0;
    wait_lvl(1'b1, 1'b1);
    // Enable while the pin is asserted must outlive the release
    host.frame(8'hA9, 0);
    ask(5'h02, 8'h00, 1'b0);
    wp_n = 1'b1;
    step(60);
    `CHK(guard, 1'b1)
    host.frame(8'h9A, 0);
    step(6);
    `CHK(guard, 1'b0)
    $display("command test done");
  endtask : t_cmd
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    req = 1'b0;
    sec = 5'h00;
    pg = 8'h00;
    exp_b = 8'h00;
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    step(6);
    t_reset();
    t_pin();
    t_erase();
    t_prog();
    t_cmd();
    conclude();
  end
  // Watchdog: about 27 times the expected run of roughly 730 clocks
  initial
  begin
    #400000;
    num_errors++;
    conclude();
  end
endmodule : sector_protection_control_test
